// file: logic/blc_dimming_top.sv
`timescale 1ns/1ps
`include "blc_cfg.svh"

module blc_dimming_top #(
  parameter int unsigned CYC_PER_US      = `BLC_SYS_CLK_MHZ,
  parameter int unsigned TIMEOUT_SAMPLES =
    `BLC_PWM_TIMEOUT_US * `BLC_SAMPLE_MHZ
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  input  wire logic        pwmIn,
  output logic      [15:0] channelSinkCurrent,
  output logic      [4:0]  fullScaleSinkCurrent,
  output logic      [7:0]  sinkEnable,
  output logic             boostEnable
);

  initial begin
    if (CYC_PER_US < 1 || CYC_PER_US > 1000)
      $error("blc_dimming_top: CYC_PER_US out of range");
    if (TIMEOUT_SAMPLES < 2 || TIMEOUT_SAMPLES > 1000000)
      $error("blc_dimming_top: TIMEOUT_SAMPLES out of range");
  end

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]  runCtrl_reg;
  logic [7:0]  genCtrl_reg;
  logic [7:0]  rampHyst_reg;
  logic [7:0]  briLow_reg;
  logic [7:0]  briHigh_reg;
  logic [7:0]  sinkEn_reg;
  logic [7:0]  onOffTime_reg;
  logic [7:0]  fullScale_reg;
  logic [10:0] code_reg;

  logic        wrRun;
  logic        wrGen;
  logic        wrRamp;
  logic        wrLow;
  logic        wrHigh;
  logic        wrSink;
  logic        wrOnOff;
  logic        wrFull;

  assign wrRun   = regWrEn && regAddr == `BLC_OFS_RUN_CTRL;
  assign wrGen   = regWrEn && regAddr == `BLC_OFS_GEN_CTRL;
  assign wrRamp  = regWrEn && regAddr == `BLC_OFS_RAMP_HYST;
  assign wrLow   = regWrEn && regAddr == `BLC_OFS_BRI_LOW;
  assign wrHigh  = regWrEn && regAddr == `BLC_OFS_BRI_HIGH;
  assign wrSink  = regWrEn && regAddr == `BLC_OFS_SINK_EN;
  assign wrOnOff = regWrEn && regAddr == `BLC_OFS_ONOFF_TIME;
  assign wrFull  = regWrEn && regAddr == `BLC_OFS_FULL_SCALE;

  // control registers, defaults after reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      runCtrl_reg   <= `BLC_RST_RUN_CTRL;
      genCtrl_reg   <= `BLC_RST_GEN_CTRL;
      rampHyst_reg  <= `BLC_RST_RAMP_HYST;
      briLow_reg    <= `BLC_RST_BRI_LOW;
      briHigh_reg   <= `BLC_RST_BRI_HIGH;
      sinkEn_reg    <= `BLC_RST_SINK_EN;
      onOffTime_reg <= `BLC_RST_ONOFF_TIME;
      fullScale_reg <= `BLC_RST_FULL_SCALE;
    end else begin
      if (wrRun)   runCtrl_reg   <= regWrData;
      if (wrGen)   genCtrl_reg   <= regWrData;
      if (wrRamp)  rampHyst_reg  <= regWrData;
      if (wrLow)   briLow_reg    <= regWrData;
      if (wrHigh)  briHigh_reg   <= regWrData;
      if (wrSink)  sinkEn_reg    <= regWrData;
      if (wrOnOff) onOffTime_reg <= regWrData;
      if (wrFull)  fullScale_reg <= regWrData;
    end
  end

  // low bits wait in their register until the high byte lands
  always_ff @(posedge sys_clk) begin
    if (!rst_n) code_reg <= 11'h000;
    else if (wrHigh) code_reg <= {regWrData, briLow_reg[2:0]};
  end

  // ****************************************
  // pwm measurement
  // ****************************************
  logic [3:0]  sampleDiv_reg;
  logic        sampleEn;
  logic        pwmActive;
  logic [10:0] measDuty;
  logic        noPulse;
  logic        pwmEn;

  assign sampleEn  = (sampleDiv_reg == 4'(`BLC_SAMPLE_DIV - 1));
  assign pwmActive = pwmIn ^ genCtrl_reg[`BLC_PWM_LOW_BIT];
  assign pwmEn     = genCtrl_reg[`BLC_PWM_EN_BIT];

  // 20MHz sampling enable from the system clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n || sampleEn) sampleDiv_reg <= 4'h0;
    else sampleDiv_reg <= sampleDiv_reg + 4'h1;
  end

  blc_duty_meter #(
    .CNT_W           (20),
    .TIMEOUT_SAMPLES (TIMEOUT_SAMPLES)
  ) uDutyMeter (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .sampleEn  (sampleEn),
    .pwmActive (pwmActive),
    .dutyCode  (measDuty),
    .noPulse   (noPulse)
  );

  // ****************************************
  // hysteresis and duty slope
  // ****************************************
  logic [10:0] heldDuty_reg;
  logic        dirUp_reg;
  logic [10:0] hystLsb;
  logic [10:0] riseAmt;
  logic [10:0] fallAmt;
  logic [10:0] slewDuty;
  logic [31:0] slopePeriod;

  assign hystLsb = {7'h0, rampHyst_reg[`BLC_HYST_MSB:`BLC_HYST_LSB], 1'b0};
  assign riseAmt = measDuty - heldDuty_reg;
  assign fallAmt = heldDuty_reg - measDuty;
  // fixed slope per LSB, so time grows with the size of the change
  assign slopePeriod = 32'((`BLC_SLOPE_BASE_NS * CYC_PER_US + 999) / 1000)
    << fullScale_reg[`BLC_SLOPE_MSB:`BLC_SLOPE_LSB];

  // reversal needs the margin; same direction follows at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      heldDuty_reg <= 11'h000;
      dirUp_reg    <= 1'b1;
    end else if (measDuty > heldDuty_reg) begin
      if (dirUp_reg || riseAmt >= hystLsb) begin
        heldDuty_reg <= measDuty;
        dirUp_reg    <= 1'b1;
      end
    end else if (measDuty < heldDuty_reg) begin
      if (!dirUp_reg || fallAmt >= hystLsb) begin
        heldDuty_reg <= measDuty;
        dirUp_reg    <= 1'b0;
      end
    end
  end

  blc_slew #(.W(11)) uDutySlope (
    .clk    (sys_clk),
    .rst_n  (rst_n),
    .period (slopePeriod),
    .step   (11'h001),
    .target (heldDuty_reg),
    .value  (slewDuty)
  );

  // ****************************************
  // code to level mapping
  // ****************************************
  logic [19:0] expProd;
  logic [15:0] expFrac;
  logic [3:0]  expInt;
  logic [31:0] fracSq;
  logic [31:0] fracLin;
  logic [31:0] fracQuad;
  logic [17:0] mant;
  logic [25:0] mantShift;
  logic [33:0] expScaled;
  logic [15:0] expLevel;
  logic [27:0] linProd;
  logic [15:0] linLevel;
  logic [15:0] mapLevel;

  // 2^(code*log2 1.003040572) with a quadratic fraction fit, then /500
  assign expProd   = 20'(code_reg) * 20'd287;
  assign expInt    = expProd[19:16];
  assign expFrac   = expProd[15:0];
  assign fracSq    = 32'(expFrac) * 32'(expFrac);
  assign fracLin   = 32'(expFrac) * 32'd43012;
  assign fracQuad  = 32'(fracSq[31:16]) * 32'd22525;
  assign mant      = 18'h10000 + 18'(fracLin[31:16]) + 18'(fracQuad[31:16]);
  assign mantShift = 26'(mant) << expInt;
  assign expScaled = 34'(mantShift) * 34'd131;
  assign expLevel  = (expScaled[33:16] > 18'h0FFFF) ? 16'hFFFF
                   : expScaled[31:16];

  // (3+code)/2050 of full scale, 16-bit fraction
  assign linProd  = 28'(12'(code_reg) + 12'h003) * 28'd32737;
  assign linLevel = (linProd[27:10] > 18'h0FFFF) ? 16'hFFFF
                  : linProd[25:10];

  assign mapLevel = genCtrl_reg[`BLC_MAP_LIN_BIT] ? linLevel
                  : expLevel;

  // ****************************************
  // brightness transition ramp
  // ****************************************
  logic [15:0] lastTarget_reg;
  logic [15:0] rampStep_reg;
  logic [15:0] rampLevel;
  logic [15:0] tgtDiff;
  logic [31:0] rampPeriod;

  // selectable transition time in microseconds
  function automatic logic [31:0] rampTimeUs(input logic [3:0] sel);
    case (sel)
      4'h0:    rampTimeUs = 32'd1;
      4'h1:    rampTimeUs = 32'd2;
      4'h2:    rampTimeUs = 32'd5;
      4'h3:    rampTimeUs = 32'd10;
      4'h4:    rampTimeUs = 32'd20;
      4'h5:    rampTimeUs = 32'd50;
      4'h6:    rampTimeUs = 32'd100;
      4'h7:    rampTimeUs = 32'd500;
      4'h8:    rampTimeUs = 32'd1000;
      4'h9:    rampTimeUs = 32'd2000;
      4'hA:    rampTimeUs = 32'd5000;
      4'hB:    rampTimeUs = 32'd10000;
      4'hC:    rampTimeUs = 32'd50000;
      4'hD:    rampTimeUs = 32'd100000;
      4'hE:    rampTimeUs = 32'd320000;
      default: rampTimeUs = 32'd640000;
    endcase
  endfunction

  assign tgtDiff = (mapLevel > rampLevel) ? mapLevel - rampLevel
                 : rampLevel - mapLevel;
  // at most 256 steps, one LSB each below 256 LSB; the extra cycle per step lets time run up to 256 cycles past the selected one
  assign rampPeriod = (rampTimeUs(rampHyst_reg[`BLC_RAMP_SEL_MSB:
    `BLC_RAMP_SEL_LSB]) * CYC_PER_US) / `BLC_RAMP_STEPS + 32'h1;

  // new target: share the distance into equal steps
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lastTarget_reg <= 16'h0000;
      rampStep_reg   <= 16'h0001;
    end else if (mapLevel != lastTarget_reg) begin
      lastTarget_reg <= mapLevel;
      rampStep_reg   <= (tgtDiff >> 8) + 16'h0001;
    end
  end

  blc_slew #(.W(16)) uCodeRamp (
    .clk    (sys_clk),
    .rst_n  (rst_n),
    .period (rampPeriod),
    .step   (rampStep_reg),
    .target (mapLevel),
    .value  (rampLevel)
  );

  // ****************************************
  // standby and turn on/off sequencing
  // ****************************************
  blc_pkg::blc_state_t state_reg;
  blc_pkg::blc_state_t state_next;
  logic        runReq;
  logic        codeZero;
  logic [15:0] envelope;
  logic [15:0] envTarget;
  logic [3:0]  envSel;
  logic [31:0] envPeriod;

  assign codeZero = (code_reg == 11'h000);
  // standby whenever the run bit, sinks, code or duty say so
  assign runReq = runCtrl_reg[`BLC_RUN_BIT] && sinkEn_reg != 8'h00
    && !codeZero && !(pwmEn && (noPulse || heldDuty_reg == 11'h000));

  // sequencing between standby and backlight operation
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      blc_pkg::BLC_STANDBY:
        if (runReq) state_next = blc_pkg::BLC_RAMP_ON;
      blc_pkg::BLC_RAMP_ON:
        if (!runReq) state_next = blc_pkg::BLC_RAMP_OFF;
        else if (envelope == 16'hFFFF) state_next = blc_pkg::BLC_RUN;
      blc_pkg::BLC_RUN:
        if (!runReq) state_next = blc_pkg::BLC_RAMP_OFF;
      blc_pkg::BLC_RAMP_OFF:
        if (runReq) state_next = blc_pkg::BLC_RAMP_ON;
        else if (envelope == 16'h0000) state_next = blc_pkg::BLC_STANDBY;
      default: state_next = blc_pkg::BLC_STANDBY;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) state_reg <= blc_pkg::BLC_STANDBY;
    else state_reg <= state_next;
  end

  assign envTarget = (state_reg == blc_pkg::BLC_RAMP_ON ||
                      state_reg == blc_pkg::BLC_RUN) ? 16'hFFFF : 16'h0000;
  assign envSel = (envTarget == 16'hFFFF) ? onOffTime_reg[7:4]
                : onOffTime_reg[3:0];
  // base time doubles per option; 256 steps across the ramp
  assign envPeriod = (32'(`BLC_ONOFF_BASE_US) * CYC_PER_US
    / `BLC_RAMP_STEPS) << envSel;

  blc_slew #(.W(16)) uEnvelope (
    .clk    (sys_clk),
    .rst_n  (rst_n),
    .period (envPeriod),
    .step   (16'h0100),
    .target (envTarget),
    .value  (envelope)
  );

  // ****************************************
  // final level and outputs
  // ****************************************
  logic [11:0] dutyScale;
  logic [27:0] dutyProd;
  logic [15:0] dimLevel;
  logic [31:0] envSq;
  logic [15:0] envShaped;
  logic [31:0] finalProd;
  logic [7:0]  rdMux;

  // 2047 counts as exactly one so full duty costs nothing
  assign dutyScale = !pwmEn ? 12'h800
    : (slewDuty == 11'h7FF) ? 12'h800 : {1'b0, slewDuty};
  assign dutyProd  = 28'(rampLevel) * 28'(dutyScale);
  assign dimLevel  = dutyProd[26:11];
  // squared envelope is a cheap stand-in for an exponential shape
  assign envSq     = 32'(envelope) * 32'(envelope);
  assign envShaped = genCtrl_reg[`BLC_SHAPE_EXP_BIT] ? envSq[31:16]
                   : envelope;
  assign finalProd = 32'(dimLevel) * 32'(envShaped);

  // read mux; unmapped offsets read zero
  always_comb begin
    case (regAddr)
      `BLC_OFS_RUN_CTRL:   rdMux = runCtrl_reg;
      `BLC_OFS_GEN_CTRL:   rdMux = genCtrl_reg;
      `BLC_OFS_RAMP_HYST:  rdMux = rampHyst_reg;
      `BLC_OFS_BRI_LOW:    rdMux = briLow_reg;
      `BLC_OFS_BRI_HIGH:   rdMux = briHigh_reg;
      `BLC_OFS_SINK_EN:    rdMux = sinkEn_reg;
      `BLC_OFS_DUTY_LOW:   rdMux = measDuty[7:0];
      `BLC_OFS_DUTY_HIGH:  rdMux = {5'h00, measDuty[10:8]};
      `BLC_OFS_ONOFF_TIME: rdMux = onOffTime_reg;
      `BLC_OFS_FULL_SCALE: rdMux = fullScale_reg;
      default:             rdMux = 8'h00;
    endcase
  end

  // registered outputs; code zero cuts sinks and boost at once
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdData            <= 8'h00;
      channelSinkCurrent   <= 16'h0000;
      fullScaleSinkCurrent <= 5'h00;
      sinkEnable           <= 8'h00;
      boostEnable          <= 1'b0;
    end else begin
      regRdData            <= rdMux;
      fullScaleSinkCurrent <=
        fullScale_reg[`BLC_FS_MSB:`BLC_FS_LSB];
      if (state_reg == blc_pkg::BLC_STANDBY || codeZero) begin
        channelSinkCurrent <= 16'h0000;
        sinkEnable         <= 8'h00;
        boostEnable        <= 1'b0;
      end else begin
        channelSinkCurrent <= finalProd[31:16];
        sinkEnable         <= sinkEn_reg;
        boostEnable        <= !(pwmEn && noPulse);
      end
    end
  end

endmodule

// file: include/blc_cfg.svh
`ifndef BLC_CFG_SVH
`define BLC_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define BLC_OFS_RUN_CTRL     8'h01
`define BLC_OFS_GEN_CTRL     8'h02
`define BLC_OFS_RAMP_HYST    8'h03
`define BLC_OFS_BRI_LOW      8'h04
`define BLC_OFS_BRI_HIGH     8'h05
`define BLC_OFS_SINK_EN      8'h08
`define BLC_OFS_DUTY_LOW     8'h12
`define BLC_OFS_DUTY_HIGH    8'h13
`define BLC_OFS_ONOFF_TIME   8'h14
`define BLC_OFS_FULL_SCALE   8'h15

// ****************************************
// field positions
// ****************************************
`define BLC_RUN_BIT          0
`define BLC_PWM_EN_BIT       0
`define BLC_SHAPE_EXP_BIT    1
`define BLC_PWM_LOW_BIT      2
`define BLC_MAP_LIN_BIT      3
`define BLC_RAMP_SEL_MSB     6
`define BLC_RAMP_SEL_LSB     3
`define BLC_HYST_MSB         2
`define BLC_HYST_LSB         0
`define BLC_FS_MSB           7
`define BLC_FS_LSB           3
`define BLC_SLOPE_MSB        2
`define BLC_SLOPE_LSB        0

// ****************************************
// reset values
// ****************************************
`define BLC_RST_RUN_CTRL     8'h00
`define BLC_RST_GEN_CTRL     8'h00
`define BLC_RST_RAMP_HYST    8'h00
`define BLC_RST_BRI_LOW      8'h00
`define BLC_RST_BRI_HIGH     8'h00
`define BLC_RST_SINK_EN      8'h00
`define BLC_RST_ONOFF_TIME   8'h44
`define BLC_RST_FULL_SCALE   8'h00

// ****************************************
// timing
// ****************************************
`define BLC_SYS_CLK_MHZ      200
`define BLC_SAMPLE_MHZ       20
`define BLC_SAMPLE_DIV       (`BLC_SYS_CLK_MHZ / `BLC_SAMPLE_MHZ)
`define BLC_PWM_TIMEOUT_US   20000
`define BLC_ONOFF_BASE_US    512
`define BLC_RAMP_STEPS       256
`define BLC_SLOPE_BASE_NS    500

`endif

// file: include/blc_pkg.sv
package blc_pkg;

  // backlight power sequencing states
  typedef enum logic [1:0] {
    BLC_STANDBY,
    BLC_RAMP_ON,
    BLC_RUN,
    BLC_RAMP_OFF
  } blc_state_t;

endpackage

// file: logic/blc_slew.sv
`timescale 1ns/1ps

// rate limiter: moves value toward target by at most step per period
module blc_slew #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [31:0]  period,
  input  wire logic [W-1:0] step,
  input  wire logic [W-1:0] target,
  output logic      [W-1:0] value
);

  initial begin
    if (W < 2) $error("blc_slew: width too small");
  end

  logic [31:0]  tickCnt_reg;
  logic         tick;
  logic [W-1:0] diffUp;
  logic [W-1:0] diffDn;

  assign tick   = (tickCnt_reg >= period - 32'h1);
  assign diffUp = target - value;
  assign diffDn = value - target;

  // period counter; a shortened period takes effect at once
  always_ff @(posedge clk) begin
    if (!rst_n || tick) tickCnt_reg <= 32'h0;
    else tickCnt_reg <= tickCnt_reg + 32'h1;
  end

  // never overshoot: last step is clipped to the remaining distance
  always_ff @(posedge clk) begin
    if (!rst_n) value <= '0;
    else if (tick && target > value)
      value <= (diffUp <= step) ? target : value + step;
    else if (tick && target < value)
      value <= (diffDn <= step) ? target : value - step;
  end

endmodule

// file: logic/blc_duty_meter.sv
`timescale 1ns/1ps

// duty meter: counts samples of active time and period, divides to 11 bits
module blc_duty_meter #(
  parameter int unsigned CNT_W           = 20,
  parameter int unsigned TIMEOUT_SAMPLES = 400000
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sampleEn,
  input  wire logic        pwmActive,
  output logic      [10:0] dutyCode,
  output logic             noPulse
);

  initial begin
    if (TIMEOUT_SAMPLES >= (2**CNT_W)) $error("blc_duty_meter: CNT_W");
  end

  logic [CNT_W-1:0]    highCnt_reg;
  logic [CNT_W-1:0]    perCnt_reg;
  logic [CNT_W-1:0]    idleCnt_reg;
  logic [CNT_W-1:0]    divisor_reg;
  logic [CNT_W+10:0]   rem_reg;
  logic [3:0]          bitIdx_reg;
  logic                busy_reg;
  logic                prev_reg;
  logic [10:0]         quot_reg;
  logic                riseEdge;
  logic                anyEdge;
  logic [CNT_W+10:0]   shifted;
  logic [CNT_W+10:0]   numer;

  assign riseEdge = sampleEn && pwmActive && !prev_reg;
  assign anyEdge  = sampleEn && (pwmActive != prev_reg);
  assign shifted  = {11'h0, divisor_reg} << bitIdx_reg;
  // active samples times 2047, so full period maps to full scale
  assign numer    = ({11'h0, highCnt_reg} << 11) - {11'h0, highCnt_reg};

  // sample counting; a rising edge closes one period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      highCnt_reg <= '0;
      perCnt_reg  <= '0;
      prev_reg    <= 1'b0;
    end else if (sampleEn) begin
      prev_reg <= pwmActive;
      if (riseEdge) begin
        highCnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1};
        perCnt_reg  <= {{(CNT_W-1){1'b0}}, 1'b1};
      end else if (perCnt_reg != '1) begin
        perCnt_reg  <= perCnt_reg + 1'b1;
        highCnt_reg <= highCnt_reg + {{(CNT_W-1){1'b0}}, pwmActive};
      end
    end
  end

  // restoring division, one quotient bit per clock
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_reg    <= 1'b0;
      bitIdx_reg  <= 4'h0;
      rem_reg     <= '0;
      divisor_reg <= '0;
      quot_reg    <= 11'h0;
      dutyCode    <= 11'h000;
    end else if (riseEdge && !busy_reg && perCnt_reg != '0) begin
      busy_reg    <= 1'b1;
      bitIdx_reg  <= 4'hA;
      rem_reg     <= numer;
      divisor_reg <= perCnt_reg;
      quot_reg    <= 11'h0;
    end else if (busy_reg) begin
      if (rem_reg >= shifted) begin
        rem_reg            <= rem_reg - shifted;
        quot_reg[bitIdx_reg] <= 1'b1;
      end
      if (bitIdx_reg == 4'h0) begin
        busy_reg <= 1'b0;
        dutyCode <= (rem_reg >= shifted) ? (quot_reg | 11'h001) : quot_reg;
      end else begin
        bitIdx_reg <= bitIdx_reg - 4'h1;
      end
    end
  end

  // no edge for the timeout: stuck active keeps the last duty and clears no pulse, stuck idle no pulse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idleCnt_reg <= '0;
      noPulse     <= 1'b1;
    end else if (anyEdge) begin
      idleCnt_reg <= '0;
      noPulse     <= 1'b0;
    end else if (sampleEn) begin
      if (idleCnt_reg < CNT_W'(TIMEOUT_SAMPLES))
        idleCnt_reg <= idleCnt_reg + 1'b1;
      else
        noPulse <= !pwmActive;
    end
  end

endmodule

// file: logic/blc_unused_placeholder_none.sv
`timescale 1ns/1ps

// file: verification/blc_pwm_host.sv
`timescale 1ns/1ps
// ****
// host pwm source
// ****
module blc_pwm_host (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic        activeLow,
  input  wire logic [15:0] highCyc,
  input  wire logic [15:0] periodCyc,
  output logic             pwmIn
);
  logic [15:0] cntReg = 16'h0000;
  // period count, moved off the sampling edge
  always_ff @(negedge clk) begin
    cntReg <= (cntReg + 16'h0001 < periodCyc) ? cntReg + 16'h0001 : 16'h0000;
  end
  // a stopped source rests inactive, so it reads as no pulse
  assign pwmIn = activeLow ^ (run && cntReg < highCyc);
endmodule

// file: verification/blc_dimming_chk.sv
`timescale 1ns/1ps
// ****
// dimming port checker
// ****
module blc_dimming_chk #(
  parameter int unsigned CYC_PER_US      = 200,
  parameter int unsigned TIMEOUT_SAMPLES = 400000
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        regWrEn,
  input wire logic [7:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic        pwmIn,
  input wire logic [15:0] channelSinkCurrent,
  input wire logic [4:0]  fullScaleSinkCurrent,
  input wire logic [7:0]  sinkEnable,
  input wire logic        boostEnable
);
  // margin covers the off ramp at the shortest off time only
  localparam int unsigned QUIET = TIMEOUT_SAMPLES * 10 + 600 * CYC_PER_US;
  logic [7:0]  genReg;
  logic [4:0]  fsReg;
  logic [2:0]  lowReg;
  logic        zeroReg;
  logic        runReg;
  logic [31:0] quietReg;
  // write decodes
  wire         wrGen  = regWrEn && regAddr == 8'h02;
  wire         wrLow  = regWrEn && regAddr == 8'h04;
  wire         wrHigh = regWrEn && regAddr == 8'h05;
  wire         wrRun  = regWrEn && regAddr == 8'h01;
  wire         wrFs   = regWrEn && regAddr == 8'h15;
  // shadows of written fields; quiet time counts at the idle level
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      genReg   <= 8'h00;
      fsReg    <= 5'h00;
      lowReg   <= 3'h0;
      zeroReg  <= 1'b1;
      runReg   <= 1'b0;
      quietReg <= 32'h0;
    end else begin
      if (wrGen) genReg <= regWrData;
      if (wrFs) fsReg <= regWrData[7:3];
      if (wrLow) lowReg <= regWrData[2:0];
      if (wrHigh) zeroReg <= regWrData == 8'h00 && lowReg == 3'h0;
      if (wrRun && regWrData[0]) runReg <= 1'b1;
      quietReg <= (pwmIn == genReg[2]) ? quietReg + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_rst;
    disable iff (1'b0) !rst_n |=> channelSinkCurrent == 16'h0000
      && !boostEnable && sinkEnable == 8'h00 && fullScaleSinkCurrent == 5'h00;
  endproperty
  property p_rd;
    wrLow ##1 regAddr == 8'h04 |=> regRdData == $past(regWrData, 2);
  endproperty
  property p_unmap; regAddr == 8'h20 |=> regRdData == 8'h00; endproperty
  property p_duty; regAddr == 8'h13 |=> regRdData[7:3] == 5'h00; endproperty
  property p_fs; !wrFs [*3] |-> fullScaleSinkCurrent == fsReg; endproperty
  property p_zero;
    zeroReg [*3] |-> channelSinkCurrent == 16'h0000 && !boostEnable;
  endproperty
  property p_idle; !runReg |-> !boostEnable; endproperty
  property p_quiet; genReg[0] && quietReg > QUIET |-> !boostEnable; endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
  a_rd: assert property (p_rd) else $error("low bits readback");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_duty: assert property (p_duty) else $error("duty high bits");
  a_fs: assert property (p_fs) else $error("full scale code");
  a_zero: assert property (p_zero) else $error("code zero lit");
  a_idle: assert property (p_idle) else $error("boost before run");
  a_quiet: assert property (p_quiet) else $error("no timeout");
  c_on: cover property ($rose(boostEnable));
  c_pwm: cover property (genReg[0] && boostEnable);
  c_out: cover property (genReg[0] && quietReg > QUIET);
endmodule
bind blc_dimming_top blc_dimming_chk #(.CYC_PER_US(CYC_PER_US),
  .TIMEOUT_SAMPLES(TIMEOUT_SAMPLES)) blc_dimming_chk_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regAddr(regAddr),
  .regWrData(regWrData), .regRdData(regRdData), .pwmIn(pwmIn),
  .channelSinkCurrent(channelSinkCurrent),
  .fullScaleSinkCurrent(fullScaleSinkCurrent),
  .sinkEnable(sinkEnable), .boostEnable(boostEnable));

// file: verification/test_backlight_dimming_control.sv
`timescale 1ns/1ps
// ****
// dimming bench
// ****
module test_backlight_dimming_control;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        regWrEn = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        hostRun = 1'b0;
  logic        hostLow = 1'b0;
  logic        pwmIn;
  logic [7:0]  rdData;
  logic [15:0] cur;
  logic [4:0]  fsCur;
  logic        boostEn;
  logic [7:0]  sinkEn;
  int          n_fail = 0;
  int          compares = 0;
  // 200 MHz
  always #2.5 sys_clk = ~sys_clk;
  // short counts keep ramps within the run; the timeout must still
  // outlast the 160-sample inactive phase of the host pulse train
  blc_dimming_top #(.CYC_PER_US(1), .TIMEOUT_SAMPLES(250))
    blc_dimming_top_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(rdData), .pwmIn(pwmIn),
    .channelSinkCurrent(cur), .fullScaleSinkCurrent(fsCur),
    .sinkEnable(sinkEn), .boostEnable(boostEn));
  blc_pwm_host blc_pwm_host_inst (.clk(sys_clk), .run(hostRun),
    .activeLow(hostLow), .highCyc(16'h0190), .periodCyc(16'h07D0),
    .pwmIn(pwmIn));
  task automatic chk(input string n, input logic [15:0] e, g, tol);
    compares++;
    if ($isunknown(g) || (g > e ? g - e : e - g) > tol) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    idle(1);
    regWrEn = 1'b0;
    idle(1);
  endtask
  task automatic rd(input logic [7:0] a, e);
    regAddr = a;
    idle(2);
    chk("regRdData", {8'h00, e}, {8'h00, rdData}, 16'h0000);
  endtask
  task automatic t_reset_values;
    rd(8'h14, 8'h44);
    rd(8'h02, 8'h00);
    rd(8'h20, 8'h00);
    wr(8'h12, 8'hFF);
    rd(8'h12, 8'h00);
    wr(8'h15, 8'hFB);
    chk("fullScale", 16'h001F, {11'h000, fsCur}, 16'h0000);
  endtask
  task automatic t_i2c_dimming;
    wr(8'h08, 8'hFF);
    wr(8'h14, 8'h00);
    wr(8'h02, 8'h08);
    wr(8'h04, 8'h07);
    wr(8'h05, 8'h80);
    wr(8'h01, 8'h01);
    idle(900);
    chk("boostEnable", 16'h0001, {15'h0000, boostEn}, 16'h0000);
    chk("sinkEnable", 16'h00FF, {8'h00, sinkEn}, 16'h0000);
    chk("current", 16'h811F, cur, 16'h0020);
    wr(8'h04, 8'h00);
    idle(300);
    chk("current", 16'h811F, cur, 16'h0020);
    wr(8'h05, 8'h80);
    idle(300);
    chk("current", 16'h803F, cur, 16'h0020);
    wr(8'h02, 8'h00);
    idle(300);
    chk("current", 16'h0B77, cur, 16'h0100);
    wr(8'h05, 8'h00);
    idle(10);
    chk("current", 16'h0000, cur, 16'h0000);
    chk("sinkEnable", 16'h0000, {8'h00, sinkEn}, 16'h0000);
  endtask
  task automatic t_pwm_dimming;
    hostRun = 1'b1;
    idle(2000);
    wr(8'h03, 8'h06);
    wr(8'h05, 8'h80);
    wr(8'h02, 8'h09);
    idle(6000);
    rd(8'h12, 8'h99);
    rd(8'h13, 8'h01);
    chk("boostEnable", 16'h0001, {15'h0000, boostEn}, 16'h0000);
    // (3+1024)/2050 of full scale times 20 percent duty
    chk("current", 16'h19A6, cur, 16'h0020);
    wr(8'h02, 8'h0D);
    hostLow = 1'b1;
    idle(6000);
    rd(8'h12, 8'h99);
    hostRun = 1'b0;
    // 250 samples of ten clocks, plus the decision and output stage
    idle(2700);
    chk("boostEnable", 16'h0000, {15'h0000, boostEn}, 16'h0000);
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    idle(16);
    rst_n = 1'b1;
    idle(2);
    t_reset_values();
    t_i2c_dimming();
    t_pwm_dimming();
    print_verdict();
  end
  // watchdog, twice the length of the scenarios
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    print_verdict();
  end
endmodule
